// file: inc/ssq_pkg.sv
// Constants, types and number-format helpers of the supply sequencer.
// Assumes a single 125 MHz system clock shared by all users of the package.
package ssq_pkg;
	localparam int         NCH           = 8;
	localparam int         CH_W          = 3;
	localparam int         CLK_PERIOD_NS = 8;
	localparam int         TICK_NS       = 1000;
	localparam int         TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	localparam logic [63:0] US_PER_MS    = 64'd1000;
	localparam logic [7:0] PAGE_ALL      = 8'hff;
	localparam logic [7:0] VOUT_MODE_VAL = 8'h13;

	localparam logic [7:0] CMD_PAGE      = 8'h00;
	localparam logic [7:0] CMD_CLEAR     = 8'h03;
	localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
	localparam logic [7:0] CMD_UV_LIMIT  = 8'h44;
	localparam logic [7:0] CMD_OT_WARN   = 8'h51;
	localparam logic [7:0] CMD_UT_WARN   = 8'h52;
	localparam logic [7:0] CMD_UT_FAULT  = 8'h53;
	localparam logic [7:0] CMD_UT_ACT    = 8'h54;
	localparam logic [7:0] CMD_VIN_OVF   = 8'h55;
	localparam logic [7:0] CMD_VIN_OVACT = 8'h56;
	localparam logic [7:0] CMD_VIN_OVW   = 8'h57;
	localparam logic [7:0] CMD_VIN_UVW   = 8'h58;
	localparam logic [7:0] CMD_VIN_UVF   = 8'h59;
	localparam logic [7:0] CMD_VIN_UVACT = 8'h5a;
	localparam logic [7:0] CMD_PG_ON     = 8'h5e;
	localparam logic [7:0] CMD_PG_OFF    = 8'h5f;
	localparam logic [7:0] CMD_T_ON      = 8'h60;
	localparam logic [7:0] CMD_T_RISE    = 8'h61;
	localparam logic [7:0] CMD_T_MAX     = 8'h62;
	localparam logic [7:0] CMD_MAX_ACT   = 8'h63;
	localparam logic [7:0] CMD_T_OFF     = 8'h64;
	localparam logic [7:0] CMD_ST_BYTE   = 8'h78;
	localparam logic [7:0] CMD_ST_WORD   = 8'h79;
	localparam logic [7:0] CMD_ST_VOUT   = 8'h7a;
	localparam logic [7:0] CMD_ST_INPUT  = 8'h7c;
	localparam logic [7:0] CMD_ST_TEMP   = 8'h7d;

	localparam logic [15:0] OT_WARN_RST  = 16'hea30;
	localparam logic [15:0] UT_WARN_RST  = 16'h8000;
	localparam logic [15:0] UT_FAULT_RST = 16'he580;
	localparam logic [7:0]  UT_ACT_RST   = 8'hb8;
	localparam logic [15:0] VIN_OVF_RST  = 16'hd3c0;
	localparam logic [7:0]  VIN_OVA_RST  = 8'h80;
	localparam logic [15:0] VIN_OVW_RST  = 16'hd380;
	localparam logic [15:0] VIN_UVW_RST  = 16'h8000;
	localparam logic [15:0] VIN_UVF_RST  = 16'h8000;
	localparam logic [7:0]  VIN_UVA_RST  = 8'h00;

	// Flag positions inside the status bytes
	localparam int SB_OFF = 6, SB_VIN_UV = 3, SB_TEMP = 2, SB_OTHER = 0;
	localparam int SW_VOUT = 7, SW_INPUT = 5, SW_PG_N = 3;
	localparam int SV_TON_MAX = 2;
	localparam int FL_HI_FAULT = 3, FL_HI_WARN = 2, FL_LO_WARN = 1, FL_LO_FAULT = 0;

	typedef enum logic [2:0] {
		SQ_OFF     = 3'b000,
		SQ_ON_DLY  = 3'b001,
		SQ_RUN     = 3'b011,
		SQ_OFF_DLY = 3'b010,
		SQ_HALT    = 3'b110
	} ssq_state_e;

	typedef struct packed {
		logic [7:0]  code;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} ssq_cmd_s;

	typedef struct packed {
		logic [15:0] data;
		logic        valid;
		logic        err;
	} ssq_rsp_s;

	typedef struct packed {
		logic [15:0] pg_on;
		logic [15:0] pg_off;
		logic [15:0] uv_lim;
		logic [15:0] t_on;
		logic [15:0] t_rise;
		logic [15:0] t_max;
		logic [7:0]  max_act;
		logic [15:0] t_off;
	} ssq_chan_s;

	localparam ssq_chan_s CHAN_RST = '{pg_on: 16'h1eb8, pg_off: 16'h1e14, uv_lim: 16'h1ccd,
		t_on: 16'hba00, t_rise: 16'hd280, t_max: 16'hd3c0, max_act: 8'hb8, t_off: 16'hba00};

	// 11-bit linear word to signed fixed point with 16 fraction bits
	function automatic logic signed [47:0] l11_fix(input logic [15:0] v);
		logic signed [47:0] m;
		logic [5:0]         sh;
		m  = {{37{v[10]}}, v[10:0]};
		sh = 6'({v[15], v[15:11]}) + 6'd16;
		return m <<< sh;
	endfunction

	// Time word in ms to microsecond ticks; negative clamps to zero, huge saturates
	function automatic logic [31:0] l11_us(input logic [15:0] v);
		logic signed [47:0] f;
		logic [63:0]        p;
		f = l11_fix(v);
		p = {16'h0000, f} * US_PER_MS;
		if (f < 0)
			return 32'h0;
		if (p[63:48] != 16'h0000)
			return 32'hffffffff;
		return p[47:16];
	endfunction

	// Response byte: 01/10 latch off until cleared, 11 off while present, 00 ignore
	function automatic logic act_latch(input logic [7:0] a);
		return (a[7:6] == 2'b01) || (a[7:6] == 2'b10);
	endfunction

	function automatic logic act_hold(input logic [7:0] a);
		return a[7:6] == 2'b11;
	endfunction
endpackage

// file: rtl/ssq_sequencer.sv
// Supply on/off sequencer with start-up timeout, power-good hysteresis and
// input/temperature supervision behind a decoded command port.
// Assumes measurements and command strobes come from logic on sys_clk.
//
// Contract
// - After on command, wait turn-on delay before raising the channel enable.
// - After off command, wait turn-off delay before dropping the channel enable.
// - After enable rises, wait rise time, then start servoing the output.
// - Undervoltage past the start-up limit after enable flags a timeout fault.
// - A timeout fault performs the channel's configured timeout response action; only the 01/10 latch responses act, 11 is treated as ignore.
// - Power good asserts when output is at or above the on level.
// - Power good deasserts when output is at or below the off level.
// - Die temperature at the cold fault limit performs the cold fault action.
// - Input sense above the high fault limit flags an input overvoltage fault.
// - An input overvoltage fault performs its configured response action.
// - Input sense above the high warning limit raises an overvoltage warning.
// - Input sense below the low warning limit raises an undervoltage warning.
// - Input sense below the low fault limit flags an undervoltage fault.
// - An input undervoltage fault performs its configured response action.
// - Paged read-only one-byte fault summary of the selected channel.
// - Paged read-only two-byte fault summary of the selected channel.
// - Paged read-only output voltage flag byte of the selected channel.
// - Non-paged read-only input voltage flag byte.
// - Non-paged read-only die temperature flag byte.
// - Output voltages are unsigned 16-bit with exponent -13, as mode reports.
// - Output undervoltage fault limit decides whether the channel is on at start-up.
`timescale 1ns/100ps
`default_nettype none
module ssq_sequencer (
	input  wire logic                           sys_clk,           // 125 MHz
	input  wire logic                           reset_n,           // Async, active low
	input  wire ssq_pkg::ssq_cmd_s              cmd_req,           // Decoded host command
	output var  ssq_pkg::ssq_rsp_s              cmd_rsp,           // Read data and status
	input  wire logic                           control_pin,       // Asynchronous run pin
	input  wire logic [ssq_pkg::NCH-1:0]        on_request,        // Per-channel on command
	input  wire logic [ssq_pkg::NCH-1:0][15:0]  vout_level,        // Output readings
	input  wire logic [15:0]                    input_sense_level, // Input sense reading
	input  wire logic [15:0]                    die_temp_level,    // Die temperature reading
	output logic [ssq_pkg::NCH-1:0]             channel_output_enable_pin, // Converter enable
	output logic [ssq_pkg::NCH-1:0]             servo_start,       // Servo may run
	output logic [ssq_pkg::NCH-1:0]             power_good         // Power good per channel
);
	import ssq_pkg::*;
	localparam int TICK_W = 7;
	logic              ctl_meta_q, ctl_sync_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic              tick_q;
	logic [7:0]        page_q;
	ssq_chan_s         cfg_q [NCH];
	logic [15:0]       ot_warn_q, ut_warn_q, ut_fault_q;
	logic [15:0]       vin_ovf_q, vin_ovw_q, vin_uvw_q, vin_uvf_q;
	logic [7:0]        ut_act_q, vin_ova_q, vin_uva_q;
	logic [3:0]        in_flags_q, tmp_flags_q;
	logic              glob_latch_q;
	ssq_state_e        st_q [NCH], st_d [NCH];
	logic [31:0]       tmr_q [NCH];
	logic [31:0]       t_on_us [NCH], t_rise_us [NCH], t_max_us [NCH], t_off_us [NCH];
	logic [NCH-1:0]    en_q, servo_q, pg_q, armed_q, ton_flag_q;
	logic [NCH-1:0]    uv_c, ton_fire, want;
	logic              clr, glob_off;
	logic              vin_ovf_c, vin_ovw_c, vin_uvw_c, vin_uvf_c;
	logic              ut_fault_c, ot_warn_c, ut_warn_c;
	logic signed [47:0] vin_fix, temp_fix;
	logic [CH_W-1:0]   rch;
	logic [7:0]        stat_lo, stat_hi;
	logic [15:0]       rd_val;
	logic              rd_ok, wr_ok;

	function automatic logic page_hit(input int i);
		return (page_q == PAGE_ALL) || (page_q == 8'(i));
	endfunction

	// Run pin crosses in through two flops
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			{ctl_sync_q, ctl_meta_q} <= 2'b00;
		else
			{ctl_sync_q, ctl_meta_q} <= {ctl_meta_q, control_pin};
	end

	// One microsecond tick; all delays are counted in these ticks
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TICK_W'(TICK_CYC - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q     <= 1'b0;
		end
	end

	assign clr = cmd_req.wr && (cmd_req.code == CMD_CLEAR);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			page_q <= 8'h00;
		else if (cmd_req.wr && cmd_req.code == CMD_PAGE)
			page_q <= cmd_req.wdata[7:0];
	end

	// Paged settings; the all-pages selector writes every channel at once
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NCH; i++)
				cfg_q[i] <= CHAN_RST;
		end else if (cmd_req.wr) begin
			for (int i = 0; i < NCH; i++) begin
				if (page_hit(i)) begin
					case (cmd_req.code)
						CMD_PG_ON:    cfg_q[i].pg_on   <= cmd_req.wdata;
						CMD_PG_OFF:   cfg_q[i].pg_off  <= cmd_req.wdata;
						CMD_UV_LIMIT: cfg_q[i].uv_lim  <= cmd_req.wdata;
						CMD_T_ON:     cfg_q[i].t_on    <= cmd_req.wdata;
						CMD_T_RISE:   cfg_q[i].t_rise  <= cmd_req.wdata;
						CMD_T_MAX:    cfg_q[i].t_max   <= cmd_req.wdata;
						CMD_MAX_ACT:  cfg_q[i].max_act <= cmd_req.wdata[7:0];
						CMD_T_OFF:    cfg_q[i].t_off   <= cmd_req.wdata;
						default:      cfg_q[i]         <= cfg_q[i];
					endcase
				end
			end
		end
	end

	// Device-wide limits and responses
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ot_warn_q  <= OT_WARN_RST;
			ut_warn_q  <= UT_WARN_RST;
			ut_fault_q <= UT_FAULT_RST;
			ut_act_q   <= UT_ACT_RST;
			vin_ovf_q  <= VIN_OVF_RST;
			vin_ova_q  <= VIN_OVA_RST;
			vin_ovw_q  <= VIN_OVW_RST;
			vin_uvw_q  <= VIN_UVW_RST;
			vin_uvf_q  <= VIN_UVF_RST;
			vin_uva_q  <= VIN_UVA_RST;
		end else if (cmd_req.wr) begin
			case (cmd_req.code)
				CMD_OT_WARN:   ot_warn_q  <= cmd_req.wdata;
				CMD_UT_WARN:   ut_warn_q  <= cmd_req.wdata;
				CMD_UT_FAULT:  ut_fault_q <= cmd_req.wdata;
				CMD_UT_ACT:    ut_act_q   <= cmd_req.wdata[7:0];
				CMD_VIN_OVF:   vin_ovf_q  <= cmd_req.wdata;
				CMD_VIN_OVACT: vin_ova_q  <= cmd_req.wdata[7:0];
				CMD_VIN_OVW:   vin_ovw_q  <= cmd_req.wdata;
				CMD_VIN_UVW:   vin_uvw_q  <= cmd_req.wdata;
				CMD_VIN_UVF:   vin_uvf_q  <= cmd_req.wdata;
				CMD_VIN_UVACT: vin_uva_q  <= cmd_req.wdata[7:0];
				default:       ut_act_q   <= ut_act_q;
			endcase
		end
	end

	// Input and temperature comparisons
	always_comb begin
		vin_fix    = l11_fix(input_sense_level);
		temp_fix   = l11_fix(die_temp_level);
		vin_ovf_c  = vin_fix > l11_fix(vin_ovf_q);
		vin_ovw_c  = vin_fix > l11_fix(vin_ovw_q);
		vin_uvw_c  = vin_fix < l11_fix(vin_uvw_q);
		vin_uvf_c  = vin_fix < l11_fix(vin_uvf_q);
		ut_fault_c = temp_fix <= l11_fix(ut_fault_q);
		ot_warn_c  = temp_fix > l11_fix(ot_warn_q);
		ut_warn_c  = temp_fix < l11_fix(ut_warn_q);
	end

	// Sticky flags: a new event in the clearing cycle survives the clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			in_flags_q  <= 4'h0;
			tmp_flags_q <= 4'h0;
		end else begin
			in_flags_q  <= (in_flags_q & ~{4{clr}}) | {vin_ovf_c, vin_ovw_c, vin_uvw_c, vin_uvf_c};
			tmp_flags_q <= (tmp_flags_q & ~{4{clr}}) | {1'b0, ot_warn_c, ut_warn_c, ut_fault_c};
		end
	end

	// Device-wide shutdown from input and cold faults
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			glob_latch_q <= 1'b0;
		else
			glob_latch_q <= (glob_latch_q && !clr)
				|| (vin_ovf_c && act_latch(vin_ova_q))
				|| (vin_uvf_c && act_latch(vin_uva_q))
				|| (ut_fault_c && act_latch(ut_act_q));
	end

	assign glob_off = glob_latch_q
		|| (vin_ovf_c && act_hold(vin_ova_q))
		|| (vin_uvf_c && act_hold(vin_uva_q))
		|| (ut_fault_c && act_hold(ut_act_q));

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			t_on_us[i]   = l11_us(cfg_q[i].t_on);
			t_rise_us[i] = l11_us(cfg_q[i].t_rise);
			t_max_us[i]  = l11_us(cfg_q[i].t_max);
			t_off_us[i]  = l11_us(cfg_q[i].t_off);
			uv_c[i]      = vout_level[i] < cfg_q[i].uv_lim;
			want[i]      = on_request[i] && ctl_sync_q && !glob_off;
			ton_fire[i]  = (st_q[i] == SQ_RUN) && armed_q[i] && uv_c[i]
				&& (tmr_q[i] >= t_max_us[i]);
		end
	end

	// Channel sequence; an on request during the off delay waits for the channel to stop
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			st_d[i] = st_q[i];
			case (st_q[i])
				SQ_OFF:
					if (want[i])
						st_d[i] = SQ_ON_DLY;
				SQ_ON_DLY:
					if (!want[i])
						st_d[i] = SQ_OFF;
					else if (tmr_q[i] >= t_on_us[i])
						st_d[i] = SQ_RUN;
				SQ_RUN:
					if (glob_off)
						st_d[i] = SQ_OFF;
					else if (ton_fire[i] && act_latch(cfg_q[i].max_act))
						st_d[i] = SQ_HALT;
					else if (!want[i])
						st_d[i] = SQ_OFF_DLY;
				SQ_OFF_DLY:
					if (glob_off || tmr_q[i] >= t_off_us[i])
						st_d[i] = SQ_OFF;
				SQ_HALT:
					if (clr)
						st_d[i] = SQ_OFF;
				default:
					st_d[i] = SQ_OFF;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NCH; i++) begin
				st_q[i]  <= SQ_OFF;
				tmr_q[i] <= 32'h0;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				st_q[i] <= st_d[i];
				if (st_d[i] != st_q[i])
					tmr_q[i] <= 32'h0;
				else if (tick_q && tmr_q[i] != 32'hffffffff)
					tmr_q[i] <= tmr_q[i] + 32'h1;
			end
		end
	end

	// Enable, servo release and start-up watch per channel
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			{en_q, servo_q, armed_q} <= '0;
		else begin
			for (int i = 0; i < NCH; i++) begin
				en_q[i]    <= (st_d[i] == SQ_RUN) || (st_d[i] == SQ_OFF_DLY);
				servo_q[i] <= ((st_d[i] == SQ_RUN) || (st_d[i] == SQ_OFF_DLY)) && (servo_q[i]
					|| (st_q[i] == SQ_RUN && tmr_q[i] >= t_rise_us[i]));
				if (st_q[i] == SQ_ON_DLY && st_d[i] == SQ_RUN)
					armed_q[i] <= 1'b1;
				else if (st_q[i] != SQ_RUN || ton_fire[i] || !uv_c[i])
					armed_q[i] <= 1'b0;
			end
		end
	end

	// Timeout flag is set even when the response says ignore
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			ton_flag_q <= '0;
		else
			ton_flag_q <= (ton_flag_q & ~{NCH{clr}}) | ton_fire;
	end

	// Power good hysteresis on raw 16-bit output codes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			pg_q <= '0;
		else begin
			for (int i = 0; i < NCH; i++) begin
				if (vout_level[i] >= cfg_q[i].pg_on)
					pg_q[i] <= 1'b1;
				else if (vout_level[i] <= cfg_q[i].pg_off)
					pg_q[i] <= 1'b0;
			end
		end
	end

	// Read decode; pages beyond the channel count read channel zero
	always_comb begin
		rch     = (page_q < 8'(NCH)) ? page_q[CH_W-1:0] : '0;
		stat_lo = 8'h00;
		stat_hi = 8'h00;
		stat_lo[SB_OFF]    = !en_q[rch];
		stat_lo[SB_VIN_UV] = in_flags_q[FL_LO_FAULT];
		stat_lo[SB_TEMP]   = |tmp_flags_q;
		stat_lo[SB_OTHER]  = ton_flag_q[rch] || (|in_flags_q[3:1]);
		stat_hi[SW_VOUT]   = ton_flag_q[rch];
		stat_hi[SW_INPUT]  = |in_flags_q;
		stat_hi[SW_PG_N]   = !pg_q[rch];
		rd_ok  = 1'b1;
		wr_ok  = !(cmd_req.code inside {CMD_VOUT_MODE, CMD_ST_BYTE, CMD_ST_WORD,
			CMD_ST_VOUT, CMD_ST_INPUT, CMD_ST_TEMP});
		rd_val = 16'h0000;
		case (cmd_req.code)
			CMD_PAGE:      rd_val = {8'h00, page_q};
			CMD_CLEAR:     rd_ok  = 1'b0;
			CMD_VOUT_MODE: rd_val = {8'h00, VOUT_MODE_VAL};
			CMD_UV_LIMIT:  rd_val = cfg_q[rch].uv_lim;
			CMD_OT_WARN:   rd_val = ot_warn_q;
			CMD_UT_WARN:   rd_val = ut_warn_q;
			CMD_UT_FAULT:  rd_val = ut_fault_q;
			CMD_UT_ACT:    rd_val = {8'h00, ut_act_q};
			CMD_VIN_OVF:   rd_val = vin_ovf_q;
			CMD_VIN_OVACT: rd_val = {8'h00, vin_ova_q};
			CMD_VIN_OVW:   rd_val = vin_ovw_q;
			CMD_VIN_UVW:   rd_val = vin_uvw_q;
			CMD_VIN_UVF:   rd_val = vin_uvf_q;
			CMD_VIN_UVACT: rd_val = {8'h00, vin_uva_q};
			CMD_PG_ON:     rd_val = cfg_q[rch].pg_on;
			CMD_PG_OFF:    rd_val = cfg_q[rch].pg_off;
			CMD_T_ON:      rd_val = cfg_q[rch].t_on;
			CMD_T_RISE:    rd_val = cfg_q[rch].t_rise;
			CMD_T_MAX:     rd_val = cfg_q[rch].t_max;
			CMD_MAX_ACT:   rd_val = {8'h00, cfg_q[rch].max_act};
			CMD_T_OFF:     rd_val = cfg_q[rch].t_off;
			CMD_ST_BYTE:   rd_val = {8'h00, stat_lo};
			CMD_ST_WORD:   rd_val = {stat_hi, stat_lo};
			CMD_ST_VOUT:   rd_val = {13'h0000, ton_flag_q[rch], 2'b00};
			CMD_ST_INPUT:  rd_val = {8'h00, in_flags_q, 4'h0};
			CMD_ST_TEMP:   rd_val = {8'h00, tmp_flags_q, 4'h0};
			default: begin
				rd_ok = 1'b0;
				wr_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			cmd_rsp <= '0;
		else begin
			cmd_rsp.valid <= cmd_req.rd;
			cmd_rsp.data  <= (cmd_req.rd && rd_ok) ? rd_val : 16'h0000;
			cmd_rsp.err   <= (cmd_req.rd && !rd_ok) || (cmd_req.wr && !wr_ok);
		end
	end

	assign channel_output_enable_pin = en_q;
	assign servo_start               = servo_q;
	assign power_good                = pg_q;

	default clocking dcb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	en_rise_cause_a: assert property ($rose(en_q[0]) |->
		$past(st_q[0]) == SQ_ON_DLY && $past(tmr_q[0]) >= $past(t_on_us[0]))
		else $error("enable rose before turn-on delay ended");
	off_delay_hold_a: assert property (st_q[0] == SQ_OFF_DLY && !glob_off
		&& tmr_q[0] < t_off_us[0] |=> en_q[0])
		else $error("enable dropped inside turn-off delay");
	servo_after_rise_a: assert property ($rose(servo_q[0]) |-> en_q[0]
		&& $past(st_q[0]) == SQ_RUN && $past(tmr_q[0]) >= $past(t_rise_us[0]))
		else $error("servo released before rise time");
	ton_flag_cause_a: assert property ($rose(ton_flag_q[0]) |->
		$past(st_q[0] == SQ_RUN && uv_c[0] && tmr_q[0] >= t_max_us[0]))
		else $error("timeout flag without expired undervoltage start");
	ton_halt_a: assert property (ton_fire[0] && !glob_off
		&& act_latch(cfg_q[0].max_act) |=> !en_q[0] && st_q[0] == SQ_HALT)
		else $error("timeout response did not halt channel");
	pg_assert_a: assert property (vout_level[0] >= cfg_q[0].pg_on |=> pg_q[0])
		else $error("power good missing above on level");
	pg_deassert_a: assert property (vout_level[0] <= cfg_q[0].pg_off
		&& vout_level[0] < cfg_q[0].pg_on |=> !pg_q[0])
		else $error("power good held below off level");
	cold_shutdown_a: assert property (ut_fault_c && act_latch(ut_act_q) |-> ##2 !en_q[0])
		else $error("cold fault did not shut channel");
	vin_ov_flag_a: assert property (vin_ovf_c |=> in_flags_q[FL_HI_FAULT])
		else $error("input overvoltage fault not flagged");
	vin_ov_hold_a: assert property (vin_ovf_c && act_hold(vin_ova_q) |=> !en_q[0])
		else $error("input overvoltage hold response ignored");

	en_rise_c: cover property ($rose(en_q[0]));
	servo_go_c: cover property ($rose(servo_q[0]));
	ton_fault_c: cover property ($rose(ton_flag_q[0]));
	pg_cycle_c: cover property ($rose(pg_q[0]) ##[1:1000] $fell(pg_q[0]));
endmodule // ssq_sequencer
`default_nettype wire

// file: test/ssq_conv_model.sv
// Converter model: output reaches its target a fixed time after enable.
// Assumes enables come from the sequencer on sys_clk; disabled outputs read zero.
`timescale 1ns/100ps
`default_nettype none
module ssq_conv_model #(parameter int RAMP = 20) (
	input  wire logic                          sys_clk, // Clock
	input  wire logic [ssq_pkg::NCH-1:0]       en,      // Converter enables
	input  wire logic [ssq_pkg::NCH-1:0][15:0] tgt,     // Settled outputs
	output var  logic [ssq_pkg::NCH-1:0][15:0] vout     // Output readings
);
	import ssq_pkg::*;
	int cnt[NCH];
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NCH; i++) begin
			cnt[i] <= en[i] ? cnt[i] + 1 : 0;
			vout[i] <= (en[i] && cnt[i] >= RAMP) ? tgt[i] : 16'h0000;
		end
	end
endmodule // ssq_conv_model
`default_nettype wire

// file: test/supply_sequencing_limit_commands_tb.sv
// Testbench of the supply sequencer: registers, sequencing, limits, flags.
// Assumes a converter model on the enables; times shortened to a few us.
`timescale 1ns/100ps
`default_nettype none
module supply_sequencing_limit_commands_tb;
	import ssq_pkg::*;
	logic sys_clk = 0, reset_n = 0, control_pin = 0;
	ssq_cmd_s cmd_req = '0;
	ssq_rsp_s cmd_rsp;
	logic [NCH-1:0] on_request = '0, en, servo, pg;
	logic [NCH-1:0][15:0] vout, tgt = '0;
	logic [15:0] vin = 16'hd300, temp = 16'hdb20, rd;
	logic er, vl;
	int failures = 0, tests_run = 0, seed = 90, cyc = 0, n;
	logic [7:0] codes[$] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58,
		8'h59, 8'h5a, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64};
	logic [15:0] dflt[$] = '{16'hea30, 16'h8000, 16'he580, 16'h00b8, 16'hd3c0, 16'h0080,
		16'hd380, 16'h8000, 16'h8000, 16'h0000, 16'h1eb8, 16'h1e14, 16'hba00, 16'hd280,
		16'hd3c0, 16'h00b8, 16'hba00};
	always #4 sys_clk = ~sys_clk;
	ssq_sequencer DUT (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_req(cmd_req),
		.cmd_rsp(cmd_rsp), .control_pin(control_pin), .on_request(on_request),
		.vout_level(vout), .input_sense_level(vin), .die_temp_level(temp),
		.channel_output_enable_pin(en), .servo_start(servo), .power_good(pg));
	ssq_conv_model #(.RAMP(20)) conv (.sys_clk(sys_clk), .en(en), .tgt(tgt), .vout(vout));
	task automatic test_done();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One command; the registered answer is sampled at the edge after the taking edge
	task automatic cmd(input logic [7:0] c, input logic w, input logic [15:0] d);
		@(posedge sys_clk);
		cmd_req <= '{code: c, wr: w, rd: !w, wdata: d};
		@(posedge sys_clk);
		cmd_req <= '0;
		@(posedge sys_clk);
		rd = cmd_rsp.data;
		er = cmd_rsp.err;
		vl = cmd_rsp.valid;
		chk(16'(vl), 16'(!w));
	endtask
	// Cycles until an output reaches a level, bounded
	task automatic wait_for(input int ch, input int sel, input logic lvl);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (((sel == 0) ? en[ch] : (sel == 1) ? servo[ch] : pg[ch]) !== lvl
			&& n < 3000);
	endtask
	// Reference conversion: floor of mantissa * 2^exp ms in us
	function automatic int ticks(input logic [15:0] v);
		return $rtoi($floor($itor($signed(v[10:0])) * (2.0 ** $signed(v[15:11])) * 1000.0));
	endfunction
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 60000) begin
			failures++;
			test_done();
		end
	end
	// Enable or servo edge lands within one tick of the programmed time, plus pipeline slack
	task automatic in_window(input logic [15:0] t);
		chk(16'(n >= (ticks(t) - 1) * TICK_CYC && n <= (ticks(t) + 1) * TICK_CYC + 4), 1);
	endtask
	initial begin
		logic [15:0] w;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1;
		control_pin <= 1;
		tgt <= {16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1000, 16'h2000};
		foreach (codes[i]) begin
			cmd(codes[i], 0, 0);
			chk(rd, dflt[i]);
		end
		cmd(CMD_VOUT_MODE, 0, 0);
		chk(rd, 16'h0013);
		cmd(8'h99, 0, 0);
		chk(16'(er), 1);
		chk(rd, 16'h0000);
		cmd(CMD_ST_BYTE, 1, 16'h0000);
		chk(16'(er), 1);
		w = 16'($random(seed));
		cmd(CMD_PG_ON, 1, w);
		cmd(CMD_PG_ON, 0, 0);
		chk(rd, w);
		cmd(CMD_PG_ON, 1, 16'h1eb8);
		cmd(CMD_T_ON, 1, 16'hc002);
		cmd(CMD_T_RISE, 1, 16'hc003);
		cmd(CMD_T_OFF, 1, 16'hc004);
		on_request[0] <= 1;
		wait_for(0, 0, 1);
		in_window(16'hc002);
		wait_for(0, 1, 1);
		in_window(16'hc003);
		wait_for(0, 2, 1);
		chk(16'(n < 40), 1);
		cmd(CMD_ST_BYTE, 0, 0);
		chk(rd & 16'h0040, 0);
		on_request[0] <= 0;
		wait_for(0, 0, 0);
		in_window(16'hc004);
		wait_for(0, 2, 0);
		chk(16'(n < 5), 1);
		cmd(CMD_PAGE, 1, 16'h0001);
		cmd(CMD_T_ON, 1, 16'h8000);
		cmd(CMD_T_MAX, 1, 16'hc002);
		on_request[1] <= 1;
		wait_for(1, 0, 1);
		repeat (9 * TICK_CYC) @(posedge sys_clk);
		chk(16'(en[1]), 0);
		cmd(CMD_ST_VOUT, 0, 0);
		chk(rd, 16'h0004);
		cmd(CMD_ST_WORD, 0, 0);
		chk(rd & 16'h8000, 16'h8000);
		on_request[1] <= 0;
		cmd(CMD_VIN_OVACT, 1, 16'h00c0);
		on_request[0] <= 1;
		wait_for(0, 0, 1);
		vin <= 16'hd3e0;
		repeat (3) @(posedge sys_clk);
		chk(16'(en[0]), 0);
		cmd(CMD_ST_INPUT, 0, 0);
		chk(rd, 16'h00c0);
		vin <= 16'hd300;
		cmd(CMD_CLEAR, 1, 0);
		cmd(CMD_VIN_UVW, 1, 16'hd240);
		cmd(CMD_VIN_UVF, 1, 16'hd200);
		vin <= 16'hd100;
		repeat (3) @(posedge sys_clk);
		cmd(CMD_ST_INPUT, 0, 0);
		chk(rd, 16'h0030);
		vin <= 16'hd300;
		temp <= 16'he580;
		repeat (3) @(posedge sys_clk);
		cmd(CMD_ST_TEMP, 0, 0);
		chk(rd, 16'h0030);
		temp <= 16'heb48;
		cmd(CMD_CLEAR, 1, 0);
		cmd(CMD_ST_TEMP, 0, 0);
		chk(rd, 16'h0040);
		test_done();
	end
endmodule // supply_sequencing_limit_commands_tb
`default_nettype wire
